// ### rtl/adc_fmt_regs.svh
`ifndef ADC_FMT_REGS_SVH
`define ADC_FMT_REGS_SVH

// register byte addresses, one aligned word each
`define OFS_CTRL_MAIN   8'h00
`define OFS_CTRL_FMT    8'h04
`define OFS_TRIG_SEL    8'h08
`define OFS_RES_HIGH    8'h0C
`define OFS_RES_LOW     8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_MASK    8'h18

// converter_control_main fields
`define CM_ON_BIT       0
`define CM_GO_BIT       1
`define CM_CHAN         6:2
// converter_control_format fields
`define CF_JUSTIFY_BIT  7
`define CF_CCS          6:4
`define CF_PREF         1:0
// converter_trigger_select field
`define TS_TRIG         7:4
// interrupt status and mask field
`define IRQ_DONE_BIT    0

// reset values of control state
`define RST_CHAN        5'h00
`define RST_CCS         3'h0
`define RST_PREF        2'h0
`define RST_TRIG        4'h0

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### rtl/adc_fmt_pkg.sv
`default_nettype none

package adc_fmt_pkg;

  // converter sequence, gray coded along idle, start, wait
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b11
  } conv_state_t;

  // both result bytes travel together
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;

endpackage

`default_nettype wire

// ### rtl/result_packer.sv
`timescale 1ns/1ps
`default_nettype none

module result_packer
  import adc_fmt_pkg::*;
(
  // format and raw result
  input  wire logic         justify_i,
  input  wire logic [9:0]   data_i,
  // justified byte pair
  output result_pair_t      pair_o
);

  // right when justify is 1, left when 0; unused bits load as zero
  assign pair_o.high = justify_i ? {6'h00, data_i[9:8]}  // see [R2] [R7]
                                 : data_i[9:2];          // see [R6]
  assign pair_o.low  = justify_i ? data_i[7:0]           // see [R3]
                                 : {data_i[1:0], 6'h00}; // see [R1] [R7]

endmodule

`default_nettype wire

// ### rtl/adc_result_formatting.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_regs.svh"

// What this block does
// [R1] left format: result bits 1:0 go to low byte bits 7:6
// [R2] right format: result bits 9:8 go to high byte bits 1:0
// [R3] right format: result bits 7:0 fill the whole low byte
// [R4] software waits an acquisition period after a channel change
// [R5] result bytes are not reset; they keep contents across resets
// [R6] left format: result bits 9:2 fill the whole high byte
// [R7] justify 1 zeroes six high bits, 0 zeroes six low bits
// [R8] software sets run flag; hardware clears it when conversion ends
// [R9] both result bytes load together in the finishing cycle
module adc_result_formatting
  import adc_fmt_pkg::*;
(
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // axi4-lite write address and data
  input  wire logic [7:0]   s_axi_awaddr_i,
  input  wire logic         s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  wire logic [31:0]  s_axi_wdata_i,
  input  wire logic [3:0]   s_axi_wstrb_i,
  input  wire logic         s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  wire logic         s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]   s_axi_araddr_i,
  input  wire logic         s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  wire logic         s_axi_rready_i,
  // analog converter core
  input  wire logic [9:0]   conv_data_i,
  input  wire logic         conv_done_i,
  input  wire logic [15:0]  trig_src_i,
  output logic              conv_start_o,
  output logic              converter_on_o,
  output logic [4:0]        input_channel_select_o,
  output logic [2:0]        conversion_clock_select_o,
  output logic [1:0]        positive_reference_select_o,
  // interrupt
  output logic              irq_o
);

  // bus state
  logic              aw_have_r;
  logic              w_have_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic              wstrb0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  // control state
  logic              on_r;
  logic [4:0]        chan_r;
  logic              justify_r;
  logic [2:0]        ccs_r;
  logic [1:0]        pref_r;
  logic [3:0]        trig_r;
  logic              trig_prev_r;
  conv_state_t       state_r;
  conv_state_t       state_nxt;
  logic              status_r;
  logic              mask_r;
  // result bytes, no reset on purpose
  logic [7:0]        high_r;
  logic [7:0]        low_r;
  result_pair_t      pair_w;

  // write channel decode
  wire        wr_fire   = aw_have_r & w_have_r & ~bvalid_r;
  wire        wr_lane   = wr_fire & wstrb0_r;
  wire        wa_main   = (awaddr_r == `OFS_CTRL_MAIN);
  wire        wa_fmt    = (awaddr_r == `OFS_CTRL_FMT);
  wire        wa_trig   = (awaddr_r == `OFS_TRIG_SEL);
  wire        wa_high   = (awaddr_r == `OFS_RES_HIGH);
  wire        wa_low    = (awaddr_r == `OFS_RES_LOW);
  wire        wa_stat   = (awaddr_r == `OFS_IRQ_STATUS);
  wire        wa_mask   = (awaddr_r == `OFS_IRQ_MASK);
  wire        wa_hit    = wa_main | wa_fmt | wa_trig | wa_high | wa_low
                        | wa_stat | wa_mask;
  wire        wr_main   = wr_lane & wa_main;
  wire        wr_high   = wr_lane & wa_high;
  wire        wr_low    = wr_lane & wa_low;

  // handshakes are combinational from held flags
  assign s_axi_awready_o = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready_o  = ~w_have_r & ~bvalid_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = ~rvalid_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;

  // address and data may come in either order
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb0_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_i & s_axi_awready_o)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_have_r <= 1'b0;
      if (s_axi_wvalid_i & s_axi_wready_o)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata_i;
        wstrb0_r <= s_axi_wstrb_i[0];
      end
      else if (wr_fire)
        w_have_r <= 1'b0;
    end
  end

  // write response, slverr for an unmapped address
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wa_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid_r <= 1'b0;
  end

  // read selection; bits above each byte read as zero
  wire [7:0]  main_rd   = {1'b0, chan_r, (state_r != ST_IDLE), on_r};
  wire [7:0]  fmt_rd    = {justify_r, ccs_r, 2'b00, pref_r};
  wire [7:0]  trig_rd   = {trig_r, 4'h0};
  wire [7:0]  ra        = s_axi_araddr_i;
  wire        ra_hit    = (ra == `OFS_CTRL_MAIN) | (ra == `OFS_CTRL_FMT)
                        | (ra == `OFS_TRIG_SEL) | (ra == `OFS_RES_HIGH)
                        | (ra == `OFS_RES_LOW) | (ra == `OFS_IRQ_STATUS)
                        | (ra == `OFS_IRQ_MASK);
  wire [7:0]  rd_byte   = (ra == `OFS_CTRL_MAIN)  ? main_rd :
                          (ra == `OFS_CTRL_FMT)   ? fmt_rd :
                          (ra == `OFS_TRIG_SEL)   ? trig_rd :
                          (ra == `OFS_RES_HIGH)   ? high_r :
                          (ra == `OFS_RES_LOW)    ? low_r :
                          (ra == `OFS_IRQ_STATUS) ? {7'h00, status_r} :
                          (ra == `OFS_IRQ_MASK)   ? {7'h00, mask_r} :
                          8'h00;

  // read data is captured at the address handshake
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_i & s_axi_arready_o)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= ra_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      rvalid_r <= 1'b0;
  end

  // start sources: software run flag or selected trigger rising edge
  wire        trig_sel  = (trig_r != `RST_TRIG) & trig_src_i[trig_r];
  wire        trig_hit  = trig_sel & ~trig_prev_r & on_r;
  wire        sw_go     = wr_main & wdata_r[`CM_GO_BIT]
                        & wdata_r[`CM_ON_BIT];
  wire        sw_stop   = wr_main & ~(wdata_r[`CM_GO_BIT]
                        & wdata_r[`CM_ON_BIT]);
  wire        load_w    = conv_done_i & (state_r == ST_WAIT);

  // a main write without both go and on aborts; done ends the run by itself
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (sw_go | trig_hit) state_nxt = ST_START; // see [R8]
      ST_START: state_nxt = sw_stop ? ST_IDLE : ST_WAIT;
      ST_WAIT:  if (load_w | sw_stop) state_nxt = ST_IDLE; // see [R8]
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // control registers
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      on_r        <= 1'b0;
      chan_r      <= `RST_CHAN;
      justify_r   <= 1'b0;
      ccs_r       <= `RST_CCS;
      pref_r      <= `RST_PREF;
      trig_r      <= `RST_TRIG;
      trig_prev_r <= 1'b0;
      state_r     <= ST_IDLE;
      mask_r      <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      trig_prev_r <= trig_sel;
      if (wr_main)
      begin
        on_r   <= wdata_r[`CM_ON_BIT];
        chan_r <= wdata_r[`CM_CHAN];
      end
      if (wr_lane & wa_fmt)
      begin
        justify_r <= wdata_r[`CF_JUSTIFY_BIT];
        ccs_r     <= wdata_r[`CF_CCS];
        pref_r    <= wdata_r[`CF_PREF];
      end
      if (wr_lane & wa_trig)
        trig_r <= wdata_r[`TS_TRIG];
      if (wr_lane & wa_mask)
        mask_r <= wdata_r[`IRQ_DONE_BIT];
    end
  end

  // sticky done flag, write one clears, a new done wins
  wire        stat_clr  = wr_lane & wa_stat & wdata_r[`IRQ_DONE_BIT];
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status_r <= 1'b0;
    else
      status_r <= load_w | (status_r & ~stat_clr);
  end

  result_packer u_packer (
    .justify_i (justify_r),
    .data_i    (conv_data_i),
    .pair_o    (pair_w)
  );

  // no reset so the last result survives any reset; one edge loads both
  always_ff @(posedge mclk_i)
  begin
    if (load_w)
    begin
      high_r <= pair_w.high; // see [R9] [R5]
      low_r  <= pair_w.low;  // see [R9]
    end
    else
    begin
      if (wr_high)
        high_r <= wdata_r[7:0];
      if (wr_low)
        low_r <= wdata_r[7:0];
    end
  end

  // converter controls and interrupt
  assign conv_start_o                = (state_r == ST_START);
  assign converter_on_o              = on_r;
  assign input_channel_select_o      = chan_r; // pacing is up to software
  assign conversion_clock_select_o   = ccs_r;
  assign positive_reference_select_o = pref_r;
  assign irq_o                       = status_r & mask_r;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_go_write;
    (state_r == ST_IDLE) && sw_go;
  endsequence
  sequence s_start_pulse;
    conv_start_o ##1 !conv_start_o;
  endsequence

  property p_left_low;
    load_w && !justify_r |=>
      low_r == {$past(conv_data_i[1:0]), 6'h00};
  endproperty
  a_left_low: assert property (p_left_low) // see [R1]
    else $error("left low byte wrong");

  property p_right_high;
    load_w && justify_r |=>
      high_r == {6'h00, $past(conv_data_i[9:8])};
  endproperty
  a_right_high: assert property (p_right_high) // see [R2]
    else $error("right high byte wrong");

  property p_right_low;
    load_w && justify_r |=> low_r == $past(conv_data_i[7:0]);
  endproperty
  a_right_low: assert property (p_right_low) // see [R3]
    else $error("right low byte wrong");

  property p_left_high;
    load_w && !justify_r |=> high_r == $past(conv_data_i[9:2]);
  endproperty
  a_left_high: assert property (p_left_high) // see [R6]
    else $error("left high byte wrong");

  property p_zero_fill;
    load_w |=> (justify_r ? high_r[7:2] == 6'h00 : low_r[5:0] == 6'h00);
  endproperty
  a_zero_fill: assert property (p_zero_fill) // see [R7]
    else $error("unused result bits not zero");

  property p_run_flag;
    s_go_write |=> s_start_pulse ##0 (main_rd[`CM_GO_BIT] == 1'b1);
  endproperty
  a_run_flag: assert property (p_run_flag) // see [R8]
    else $error("run flag start sequence wrong");

  property p_done_clears;
    load_w |=> !main_rd[`CM_GO_BIT] && status_r;
  endproperty
  a_done_clears: assert property (p_done_clears) // see [R8]
    else $error("run flag not cleared at done");

  property p_hold;
    !load_w && !wr_high && !wr_low |=> $stable(high_r) && $stable(low_r);
  endproperty
  a_hold: assert property (p_hold) // see [R5]
    else $error("result changed without cause");

  property p_pair;
    load_w |=> {high_r, low_r} == $past(pair_w);
  endproperty
  a_pair: assert property (p_pair) // see [R9]
    else $error("result pair not loaded together");

endmodule

`default_nettype wire

// ### verif/adc_result_formatting_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_regs.svh"

module adc_result_formatting_test;
  import adc_fmt_pkg::*;

  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, done;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0]  wstrb;
  logic [9:0]  cdata;
  logic [15:0] trig;
  logic [1:0]  rsp;
  wire         awready, wready, bvalid, arready, rvalid, cstart, con, irq;
  wire  [1:0]  bresp, rresp, pref;
  wire  [31:0] rdata;
  wire  [4:0]  chan;
  wire  [2:0]  ccs;
  int          fail_count, cmp_count;
  int          starts = 0;

  adc_result_formatting uut (
    .mclk_i(mclk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .conv_data_i(cdata), .conv_done_i(done),
    .trig_src_i(trig), .conv_start_o(cstart), .converter_on_o(con),
    .input_channel_select_o(chan), .conversion_clock_select_o(ccs),
    .positive_reference_select_o(pref), .irq_o(irq)
  );

  // 250 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // cycles with the start pulse high, to catch a stretched pulse
  always @(posedge mclk)
    if (cstart === 1'h1) starts <= starts + 1;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // readies sampled at the falling edge, so the rising edge sees the same
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, dh, bv;
    bv = 1'h0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!bv)
    begin
      @(negedge mclk);
      ah  = awvalid && awready;
      dh  = wvalid && wready;
      bv  = (bvalid === 1'h1);
      rsp = bresp;
      @(posedge mclk);
      if (ah) awvalid <= 1'h0;
      if (dh) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask

  task automatic rdreg(input logic [7:0] a);
    logic ak, rv;
    rv = 1'h0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!rv)
    begin
      @(negedge mclk);
      ak  = arvalid && arready;
      rv  = (rvalid === 1'h1);
      rd  = rdata;
      rsp = rresp;
      @(posedge mclk);
      if (ak) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask

  // one software-started conversion; data line scrambled after done
  task automatic conv(input logic [7:0] fmt, input logic [9:0] v);
    wr(`OFS_CTRL_FMT, {24'h0, fmt});
    wr(`OFS_CTRL_MAIN, 32'h15);
    repeat (8) @(posedge mclk); // settle after channel change
    wr(`OFS_CTRL_MAIN, 32'h17);
    rdreg(`OFS_CTRL_MAIN);
    chk(rd, 32'h17);
    @(posedge mclk);
    cdata <= v;
    done  <= 1'h1;
    @(posedge mclk);
    cdata <= ~v;
    done  <= 1'h0;
    rdreg(`OFS_CTRL_MAIN);
    chk(rd, 32'h15);
  endtask

  task automatic res(input logic [7:0] h, input logic [7:0] l);
    rdreg(`OFS_RES_HIGH);
    chk(rd, {24'h0, h});
    rdreg(`OFS_RES_LOW);
    chk(rd, {24'h0, l});
  endtask

  // reset values, unmapped answers, and a lane-off write that stores nothing
  task automatic t_bus;
    logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
    foreach (ofs[i])
    begin
      rdreg(ofs[i]);
      chk(rd, 32'h0);
    end
    rdreg(8'h1C);
    chk({rsp, rd[29:0]}, {2'h2, 30'h0});
    wr(8'h1C, 32'hFF);
    chk(rsp, 2'h2);
    wstrb <= 4'h0;
    wr(`OFS_IRQ_MASK, 32'h1);
    chk(rsp, 2'h0);
    wstrb <= 4'hF;
    rdreg(`OFS_IRQ_MASK);
    chk(rd, 32'h0);
  endtask

  task automatic t_right;
    int s0;
    s0 = starts;
    conv(8'h80, 10'h3A5);
    chk(starts - s0, 1);
    chk(chan, 5'h05);
    res(8'h03, 8'hA5);
    chk(irq, 1'h0);
  endtask

  task automatic t_irq;
    wr(`OFS_IRQ_MASK, 32'h1);
    chk(irq, 1'h1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    rdreg(`OFS_IRQ_STATUS);
    chk(rd, 32'h0);
    chk(irq, 1'h0);
  endtask

  task automatic t_left;
    conv(8'h53, 10'h2D7);
    res(8'hB5, 8'hC0);
    chk({ccs, pref, con}, {3'h5, 2'h3, 1'h1});
    chk(irq, 1'h1);
  endtask

  // results must survive a later reset untouched
  task automatic t_reset;
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    res(8'hB5, 8'hC0);
    rdreg(`OFS_CTRL_MAIN);
    chk(rd, 32'h0);
    chk(irq, 1'h0);
  endtask

  task automatic t_trig;
    int s0;
    wr(`OFS_TRIG_SEL, 32'h30);
    wr(`OFS_CTRL_MAIN, 32'h01);
    s0 = starts;
    @(posedge mclk);
    trig <= 16'h0008;
    repeat (4) @(posedge mclk);
    chk(starts - s0, 1);
    cdata <= 10'h155;
    done  <= 1'h1;
    @(posedge mclk);
    done  <= 1'h0;
    trig  <= 16'h0000;
    cdata <= 10'h2AA;
    res(8'h55, 8'h40);
    rdreg(`OFS_CTRL_MAIN);
    chk(rd, 32'h01);
    wr(`OFS_RES_LOW, 32'h3C);
    res(8'h55, 8'h3C);
  endtask

  // abort in the wait state; a stray done then leaves results alone
  task automatic t_abort;
    int s0;
    s0 = starts;
    wr(`OFS_CTRL_MAIN, 32'h17);
    wr(`OFS_CTRL_MAIN, 32'h15);
    rdreg(`OFS_CTRL_MAIN);
    chk(rd, 32'h15);
    chk(starts - s0, 1);
    @(posedge mclk);
    cdata <= 10'h3FF;
    done  <= 1'h1;
    @(posedge mclk);
    done  <= 1'h0;
    res(8'h55, 8'h3C);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, done} = '0;
    {awaddr, araddr, wdata, cdata, trig} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    t_bus;
    t_right;
    t_irq;
    t_left;
    t_reset;
    t_trig;
    t_abort;
    finish_test;
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test;
  end

endmodule

`default_nettype wire
